// >>> logic/cc_pkg.sv
package cc_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int CC_LINE_BYTES = 16;
  localparam int CC_TAG_STEP = 'h10;
  localparam int CC_DATA_STEP = 'h04;
  localparam int CC_INDEX_W = 12;
  localparam int CC_WORD_W = 14;
  localparam int CC_LINES = 4096;
  localparam int CC_WORDS = 16384;
  localparam int CC_SPAN_W = 16;
  localparam logic [31:0] CC_CACHE_LIMIT = 32'h0800_0000;

  // ****************************************
  // Tag word layout (upper half of a read)
  // ****************************************
  localparam int CC_TAG_VALID_BIT = 15;
  localparam int CC_TAG_DIRTY_BIT = 14;
  localparam int CC_TAG_ADDR_HI = 10;
  localparam int CC_TAG_ADDR_W = 11;
  localparam int CC_TAG_RD_POS = 16;
  localparam logic [15:0] CC_TAG_LOW_FILL = 16'h0000;

  // ****************************************
  // Access sizes
  // ****************************************
  localparam logic [1:0] CC_SZ_BYTE = 2'h0;
  localparam logic [1:0] CC_SZ_WORD = 2'h1;
  localparam logic [1:0] CC_SZ_LONG = 2'h2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CC_RST_DATA = 32'h0000_0000;

  typedef struct packed {
    logic cache_on;
    logic io_cache_on;
    logic device_virtual_dma_on;
    logic vme_loopback_on;
  } cc_en_type;

  typedef struct packed {
    logic req;
    logic write;
    logic tag_space;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cc_req_type;

  typedef struct packed {
    logic ack;
    logic from_cache;
    logic [31:0] rdata;
  } cc_rsp_type;

  typedef struct packed {
    logic req;
    logic write;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cc_mem_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cc_mem_rsp_type;

  function automatic logic [3:0] cc_lanes(input logic [1:0] off, input logic [1:0] size);
    logic [3:0] m;
    m = 4'hf;
    if (size == CC_SZ_BYTE) begin
      m = 4'h8 >> off;
    end else if (size == CC_SZ_WORD) begin
      m = 4'hc >> off;
    end
    return m;
  endfunction

  function automatic logic [31:0] cc_place(input logic [31:0] d, input logic [1:0] off,
                                           input logic [1:0] size);
    logic [31:0] r;
    r = d;
    if (size == CC_SZ_BYTE) begin
      r = {d[7:0], 24'h000000} >> {off, 3'h0};
    end else if (size == CC_SZ_WORD) begin
      r = {d[15:0], 16'h0000} >> {off, 3'h0};
    end
    return r;
  endfunction

  function automatic logic [31:0] cc_extract(input logic [31:0] w, input logic [1:0] off,
                                             input logic [1:0] size);
    logic [31:0] s;
    logic [31:0] r;
    s = w << {off, 3'h0};
    r = w;
    if (size == CC_SZ_BYTE) begin
      r = s >> 24;
    end else if (size == CC_SZ_WORD) begin
      r = s >> 16;
    end
    return r;
  endfunction

endpackage

// >>> logic/cc_data_ram.sv
`timescale 1ns/100ps
module cc_data_ram (
  input wire logic ref_clk_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [3:0] be_in,
  input wire logic [cc_pkg::CC_WORD_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out
);
  import cc_pkg::*;

  // ****************************************
  // Longword array, byte lane writes
  // ****************************************
  logic [31:0] mem [CC_WORDS];

  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      for (int i = 0; i < 4; i++) begin
        if (we_in && be_in[i]) begin
          mem[addr_in][i*8 +: 8] <= wdata_in[i*8 +: 8];
        end
      end
      rdata_out <= mem[addr_in];
    end
  end

endmodule // cc_data_ram

// >>> logic/cc_cache.sv
`timescale 1ns/100ps
module cc_cache (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire cc_pkg::cc_en_type enable_in,
  input wire logic [31:0] mem_top_in,
  input wire cc_pkg::cc_req_type cpu_req_in,
  input wire cc_pkg::cc_req_type diag_req_in,
  input wire cc_pkg::cc_mem_rsp_type mem_rsp_in,
  output cc_pkg::cc_rsp_type cpu_rsp_out,
  output cc_pkg::cc_rsp_type diag_rsp_out,
  output cc_pkg::cc_mem_req_type mem_req_out,
  output cc_pkg::cc_en_type enable_out
);
  import cc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {IDLE, FETCH, CHECK, MEM} cc_state_type;

  cc_state_type state_q, state_d;
  cc_req_type cur_q, cur_d;
  logic is_diag_q, is_diag_d;
  cc_rsp_type cpu_rsp_q, cpu_rsp_d;
  cc_rsp_type diag_rsp_q, diag_rsp_d;
  cc_mem_req_type mem_q, mem_d;
  cc_en_type en_q;

  logic [15:0] tag_mem [CC_LINES];
  logic [15:0] tag_rd_q;
  logic tag_we;
  logic [15:0] tag_wdata;
  logic data_we;
  logic [3:0] data_be;
  logic [31:0] data_wdata;
  logic [31:0] data_rd;

  logic [CC_INDEX_W-1:0] line_idx;
  logic [CC_WORD_W-1:0] word_idx;
  logic [1:0] off;
  logic cacheable;
  logic hit;

  // ****************************************
  // Address decode
  // ****************************************
  assign line_idx = cur_q.addr[CC_SPAN_W-1:4];
  assign word_idx = cur_q.addr[CC_SPAN_W-1:2];
  assign off = cur_q.addr[1:0];
  assign cacheable = (cur_q.addr < CC_CACHE_LIMIT) && (cur_q.addr < mem_top_in);
  assign hit = en_q.cache_on && cacheable && tag_rd_q[CC_TAG_VALID_BIT]
               && (tag_rd_q[CC_TAG_ADDR_HI:0] ==
                   cur_q.addr[CC_SPAN_W +: CC_TAG_ADDR_W]);

  // ****************************************
  // Memories
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      if (tag_we) begin
        tag_mem[line_idx] <= tag_wdata;
      end
      tag_rd_q <= tag_mem[line_idx];
    end
  end

  cc_data_ram u_data_ram (
    .ref_clk_in(ref_clk_in),
    .ce_in(ce_in),
    .we_in(data_we),
    .be_in(data_be),
    .addr_in(word_idx),
    .wdata_in(data_wdata),
    .rdata_out(data_rd)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    is_diag_d = is_diag_q;
    cpu_rsp_d = cpu_rsp_q;
    diag_rsp_d = diag_rsp_q;
    mem_d = mem_q;
    cpu_rsp_d.ack = 1'b0;
    diag_rsp_d.ack = 1'b0;
    tag_we = 1'b0;
    tag_wdata = tag_rd_q;
    data_we = 1'b0;
    data_be = cc_lanes(off, cur_q.size);
    data_wdata = cc_place(cur_q.wdata, off, cur_q.size);
    unique case (state_q)
      IDLE: begin
        if (diag_req_in.req) begin
          cur_d = diag_req_in;
          is_diag_d = 1'b1;
          state_d = FETCH;
        end else if (cpu_req_in.req) begin
          cur_d = cpu_req_in;
          is_diag_d = 1'b0;
          state_d = FETCH;
        end
      end
      FETCH: begin
        state_d = CHECK;
      end
      CHECK: begin
        state_d = IDLE;
        if (is_diag_q) begin
          diag_rsp_d.ack = 1'b1;
          diag_rsp_d.from_cache = 1'b1;
          if (cur_q.write) begin
            tag_we = cur_q.tag_space;
            tag_wdata = cur_q.wdata[31:CC_TAG_RD_POS];
            data_we = !cur_q.tag_space;
          end else if (cur_q.tag_space) begin
            diag_rsp_d.rdata = {tag_rd_q, CC_TAG_LOW_FILL};
          end else begin
            diag_rsp_d.rdata = cc_extract(data_rd, off, cur_q.size);
          end
        end else if (hit) begin
          cpu_rsp_d.ack = 1'b1;
          cpu_rsp_d.from_cache = 1'b1;
          if (cur_q.write) begin
            data_we = 1'b1;
            tag_we = 1'b1;
            tag_wdata[CC_TAG_DIRTY_BIT] = 1'b1;
          end else begin
            cpu_rsp_d.rdata = cc_extract(data_rd, off, cur_q.size);
          end
        end else begin
          mem_d.req = 1'b1;
          mem_d.write = cur_q.write;
          mem_d.be = data_be;
          mem_d.addr = {cur_q.addr[31:2], 2'h0};
          mem_d.wdata = data_wdata;
          state_d = MEM;
        end
      end
      MEM: begin
        if (mem_rsp_in.ack) begin
          mem_d.req = 1'b0;
          cpu_rsp_d.ack = 1'b1;
          cpu_rsp_d.from_cache = 1'b0;
          if (!mem_q.write) begin
            cpu_rsp_d.rdata = cc_extract(mem_rsp_in.rdata, off, cur_q.size);
          end
          state_d = IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= IDLE;
      cur_q <= '0;
      is_diag_q <= 1'b0;
      cpu_rsp_q <= '0;
      diag_rsp_q <= '0;
      mem_q <= '0;
      en_q <= '0;
    end else if (ce_in) begin
      state_q <= state_d;
      cur_q <= cur_d;
      is_diag_q <= is_diag_d;
      cpu_rsp_q <= cpu_rsp_d;
      diag_rsp_q <= diag_rsp_d;
      mem_q <= mem_d;
      en_q <= enable_in;
    end
  end

  assign cpu_rsp_out = cpu_rsp_q;
  assign diag_rsp_out = diag_rsp_q;
  assign mem_req_out = mem_q;
  assign enable_out = en_q;

endmodule // cc_cache

// >>> test/cc_cache_props.sv
`timescale 1ns/100ps
module cc_cache_props (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire cc_pkg::cc_en_type enable_in,
  input wire cc_pkg::cc_req_type diag_req_in,
  input wire cc_pkg::cc_mem_rsp_type mem_rsp_in,
  input wire cc_pkg::cc_rsp_type cpu_rsp_out,
  input wire cc_pkg::cc_rsp_type diag_rsp_out,
  input wire cc_pkg::cc_mem_req_type mem_req_out,
  input wire cc_pkg::cc_en_type enable_out
);
  import cc_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  en_copy_a: assert property ($past(ce_in && arst_n_in) |->
    enable_out == $past(enable_in)) else $error("enable copy wrong");
  off_hit_a: assert property (cpu_rsp_out.ack && cpu_rsp_out.from_cache |->
    $past(enable_out.cache_on)) else $error("hit while off");
  hit_quiet_a: assert property (cpu_rsp_out.ack && cpu_rsp_out.from_cache |->
    !mem_req_out.req && !$past(mem_req_out.req)) else $error("hit used memory");
  miss_mem_a: assert property (cpu_rsp_out.ack && !cpu_rsp_out.from_cache |->
    $past(mem_req_out.req && mem_rsp_in.ack)) else $error("miss without memory");
  mem_hold_a: assert property (mem_req_out.req && !mem_rsp_in.ack |=>
    mem_req_out.req && $stable(mem_req_out.addr)) else $error("memory request lost");
  mem_drop_a: assert property (mem_req_out.req && mem_rsp_in.ack |=>
    !mem_req_out.req) else $error("memory request stuck");
  diag_lat_a: assert property (diag_rsp_out.ack |->
    $past(diag_req_in.req) && $past(diag_req_in.req, 3) && !$past(diag_rsp_out.ack))
    else $error("diag answer early");
  mem_align_a: assert property (mem_req_out.req |-> mem_req_out.addr[1:0] == 2'h0)
    else $error("memory address unaligned");
endmodule // cc_cache_props

// >>> test/cc_mem_model.sv
`timescale 1ns/100ps
module cc_mem_model (
  input wire logic ref_clk_in,
  input wire logic [1:0] delay_in,
  input wire cc_pkg::cc_mem_req_type req_in,
  output cc_pkg::cc_mem_rsp_type rsp_out,
  output int writes_out
);
  import cc_pkg::*;
  logic [31:0] mem [int];
  logic [31:0] cur;
  int wait_q = 0;
  int a;
  initial rsp_out = '0;
  initial writes_out = 0;
  always @(posedge ref_clk_in) begin
    a = int'(req_in.addr[31:2]);
    rsp_out.ack <= 1'b0;
    rsp_out.rdata <= ~rsp_out.rdata;
    if (req_in.req && !rsp_out.ack && wait_q < delay_in) begin
      wait_q <= wait_q + 1;
    end else if (req_in.req && !rsp_out.ack) begin
      wait_q <= 0;
      cur = mem.exists(a) ? mem[a] : (req_in.addr ^ 32'h5a5a0f0f);
      for (int i = 0; i < 4; i++) begin
        if (req_in.write && req_in.be[i]) cur[8*i+:8] = req_in.wdata[8*i+:8];
      end
      mem[a] = cur;
      writes_out <= writes_out + int'(req_in.write);
      rsp_out.ack <= 1'b1;
      rsp_out.rdata <= cur;
    end
  end
endmodule // cc_mem_model

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  import cc_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  cc_en_type en = '0;
  logic [31:0] top = CC_CACHE_LIMIT;
  cc_req_type creq = '0;
  cc_req_type dreq = '0;
  cc_mem_rsp_type mrsp;
  cc_rsp_type crsp, drsp;
  cc_mem_req_type mreq;
  cc_en_type en_o;
  logic [1:0] dly = 0;
  logic [31:0] rd, w, e, a;
  logic [31:0] tv [14];
  logic fc;
  int wr_n, n0, s, o;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  cc_cache dut (.ref_clk_in(clk), .arst_n_in(rst_n), .ce_in(1'b1), .enable_in(en),
    .mem_top_in(top), .cpu_req_in(creq), .diag_req_in(dreq), .mem_rsp_in(mrsp),
    .cpu_rsp_out(crsp), .diag_rsp_out(drsp), .mem_req_out(mreq), .enable_out(en_o));
  cc_mem_model u_mem (.ref_clk_in(clk), .delay_in(dly), .req_in(mreq), .rsp_out(mrsp),
    .writes_out(wr_n));
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic acc(input int d, wr, ts, sz, input logic [31:0] ad, wd);
    cc_req_type r;
    int n;
    n = 0;
    r = '{1'b1, 1'(wr), 1'(ts), 2'(sz), ad, wd};
    @(negedge clk);
    dly = 2'($urandom);
    if (d != 0) dreq = r;
    else creq = r;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((d != 0 ? drsp.ack : crsp.ack) !== 1'b1 && n < 99);
    rd = d != 0 ? drsp.rdata : crsp.rdata;
    fc = d != 0 ? drsp.from_cache : crsp.from_cache;
    if (n >= 99) chk(0, 1);
    @(negedge clk);
    dreq.req = 1'b0;
    creq.req = 1'b0;
  endtask
  task automatic pair(input int ts, input logic [31:0] ad, wd);
    acc(1, 1, ts, 2, ad, wd);
    acc(1, 1, ts, 2, ad + (ts != 0 ? 32'h10 : 32'h4), ~wd);
    acc(1, 0, ts, 2, ad, 0);
  endtask
  function automatic logic [31:0] ext(logic [31:0] x, int o, int s);
    if (s == 0) return 32'(x[31-8*o-:8]);
    if (s == 1) return 32'(x[31-8*o-:16]);
    return x;
  endfunction
  function automatic logic [31:0] upd(logic [31:0] x, d, int o, int s);
    int n = (s == 0) ? 1 : (s == 1) ? 2 : 4;
    for (int i = 0; i < n; i++) x[31-8*(o+i)-:8] = d[8*(n-1-i)+:8];
    return x;
  endfunction
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    w = $urandom(32'h7e51);
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 14; k++) begin
      tv[k] = $urandom;
      pair(0, 32'h4 << k, tv[k]);
      chk(rd, tv[k]);
      if (k < 12) pair(1, 32'h10 << k, tv[k]);
      if (k < 12) chk(rd[31:16], tv[k][31:16]);
    end
    for (int k = 0; k < 12; k++) begin
      acc(1, 0, 1, 2, 32'h10 << k, 0);
      chk(rd[31:16], tv[k][31:16]);
    end
    $display("ram address tests done");
    e = 0;
    acc(1, 1, 0, 2, 32'h100, 0);
    repeat (60) begin
      s = $urandom_range(0, 2);
      o = (s == 2) ? 0 : (s == 1) ? 2 * $urandom_range(0, 1) : $urandom_range(0, 3);
      w = $urandom;
      if ($urandom_range(0, 1) == 1) acc(1, 1, 0, s, 32'h100 + o, w);
      if (dreq.wdata === w && dreq.write) e = upd(e, w, o, s);
      else begin
        acc(1, 0, 0, 2, 32'h100, 0);
        chk(rd, e);
      end
      acc(1, 0, 0, s, 32'h100 + o, 0);
      chk(rd, ext(e, o, s));
    end
    $display("alignment test done");
    repeat (6) begin
      a = {5'h0, 23'($urandom), 4'h0};
      w = $urandom;
      acc(1, 1, 1, 2, {16'h0, a[15:4], 4'h0}, {5'h10, a[26:16], 16'h0});
      acc(1, 1, 0, 2, {16'h0, a[15:0]}, w);
      en = cc_en_type'({1'b1, 3'($urandom)});
      repeat (2) @(negedge clk);
      chk(en_o, en);
      n0 = wr_n;
      acc(0, 0, 0, 2, a, 0);
      chk({fc, rd}, {1'b1, w});
      acc(0, 0, 0, 2, a ^ 32'h10000, 0);
      chk({fc, rd}, {1'b0, a ^ 32'h10000 ^ 32'h5a5a0f0f});
      acc(0, 1, 0, 0, a + 1, w);
      chk({fc, 32'(wr_n)}, {1'b1, 32'(n0)});
      acc(1, 0, 1, 2, {16'h0, a[15:4], 4'h0}, 0);
      chk(rd[31:16], {5'h18, a[26:16]});
      acc(1, 0, 0, 2, {16'h0, a[15:0]}, 0);
      chk(rd, upd(w, w, 1, 0));
      for (int m = 0; m < 3; m++) begin
        top = (m == 0) ? a : CC_CACHE_LIMIT;
        en.cache_on = (m != 1);
        if (m == 2) acc(1, 1, 1, 2, {16'h0, a[15:4], 4'h0}, {5'h0, a[26:16], 16'h0});
        repeat (2) @(negedge clk);
        acc(0, 0, 0, 2, a, 0);
        chk({fc, rd}, {1'b0, a ^ 32'h5a5a0f0f});
      end
    end
    $display("cache tests done");
    stop_test();
  end
endmodule // tb
bind cc_cache cc_cache_props props (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .ce_in(ce_in), .enable_in(enable_in), .diag_req_in(diag_req_in), .mem_rsp_in(mem_rsp_in),
  .cpu_rsp_out(cpu_rsp_out), .diag_rsp_out(diag_rsp_out), .mem_req_out(mem_req_out),
  .enable_out(enable_out));
